//--- hdl/fcd_decoder.sv
// frame control field decoder: parses the mpdu header, filters frames,
// requests automatic acknowledgments and steers the retry-transmit wait
// assumes octets come from same-clock phy logic, frame marks are pulses
//
// Notes on behaviour
// (R1) the control field is sixteen bits, the first two mpdu octets
// (R2) frame type in bits 2:0: beacon, data, ack, command; 4-7 reserved
// (R3) the filter passes only frame types 0 to 3 by default
// (R4) with upload_reserved_frame_types set, reserved types are received
// (R5) filtering runs in auto-ack receive mode and in basic mode
// (R6) the filter evaluates the security bit 3
// (R7) auto-ack pending bit copies ack_pending_data_flag for data requests
// (R8) ack non-broadcast data/command frames asking for it within 192 us
// (R9) retry mode waits for an ack only when ack request was set
// (R10) pan-id compression with both addresses drops the source pan-id
// (R11) destination mode bits 11:10: none, reserved, short, extended
// (R12) a present destination is pan-id first, then short or long address
// (R13) source mode in bits 15:14 uses the same encoding
// (R14) frame version bits 13:12: 2003, 2006, two reserved values
// (R15) ack_frame_version_policy decides per version whether to ack
// (R16) address filter gets type, security, compression and bits 10-15
// (R17) the ack carries the sequence number of the acknowledged frame
// (R18) first octet gives bits 7:0, second octet bits 15:8
`timescale 1ns/100ps
module fcd_decoder
    import fcd_pkg::*;
#(
    parameter int ACK_WINDOW = ACK_WINDOW_CYC
)(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // octet stream after the length octet
    input wire logic frm_start,
    input wire logic frm_dir_tx,
    input wire logic oct_valid,
    input wire logic [OCT_W-1:0] oct_data,
    input wire logic frm_end,
    input wire logic frm_crc_ok,
    // operating modes
    input wire logic auto_ack_receive_mode,
    input wire logic auto_retry_transmit_mode,
    // control bits
    input wire logic upload_reserved_frame_types,
    input wire logic ack_pending_data_flag,
    input wire logic [1:0] ack_frame_version_policy,
    input wire logic accept_secured,
    // ack transmitter handshake
    input wire logic ack_sent,
    // decoded field and address-filter inputs
    output fcd_fcf_s fcf_q,
    output logic fcf_valid_q,
    output fcd_layout_s layout_q,
    output logic frame_pass_q,
    // automatic acknowledgment
    output logic ack_start_q,
    output fcd_fcf_s ack_fcf_q,
    output logic [OCT_W-1:0] ack_seq_q,
    output logic ack_timeout_q,
    // retry-transmit control
    output logic retry_wait_ack_q,
    output logic retry_done_q
);
    // length of an address field for a mode; reserved mode counts as absent
    function automatic logic [IDX_W-1:0] adr_len(input logic [1:0] mode);
        unique case (mode)
            AM_SHORT: adr_len = SHORT_LEN; // [R11] [R13]
            AM_EXT: adr_len = EXT_LEN;
            AM_NONE, AM_RSVD: adr_len = NO_LEN;
        endcase
    endfunction : adr_len

    // octet offsets of every addressing field behind the sequence number
    function automatic fcd_layout_s fcd_layout(input fcd_fcf_s f);
        logic [IDX_W-1:0] dl;
        logic [IDX_W-1:0] sl;
        logic [IDX_W-1:0] dpl;
        logic [IDX_W-1:0] spl;
        fcd_layout_s l;
        dl = adr_len(f.dst_mode);
        sl = adr_len(f.src_mode);
        dpl = (dl != NO_LEN) ? PAN_LEN : NO_LEN; // [R12]
        // source pan-id vanishes when compressed and both ends present
        spl = (sl != NO_LEN && !(f.pan_comp && dl != NO_LEN)) ? PAN_LEN : NO_LEN; // [R10]
        l.dst_pan_ofs = HDR_OFS;
        l.dst_adr_ofs = HDR_OFS + dpl;
        l.src_pan_ofs = l.dst_adr_ofs + dl;
        l.src_adr_ofs = l.src_pan_ofs + spl;
        l.pay_ofs = l.src_adr_ofs + sl;
        fcd_layout = l;
    endfunction : fcd_layout

    fcd_parse_e state_q;
    logic [IDX_W-1:0] idx_q;
    logic [OCT_W-1:0] lo_q;
    logic [OCT_W-1:0] seq_q;
    logic bcast_q;
    logic data_req_q;
    logic dir_tx_q;
    logic [OCT_W-1:0] tx_seq_q;
    logic [31:0] ack_cnt_q;
    logic ack_busy_q;
    logic type_ok;
    logic sec_ok;
    logic ver_ok;
    logic in_body;
    logic rx_end_ok;
    logic ack_need;
    logic ack_seen;
    fcd_fcf_s ack_d;

    // parse sequencer; a new frame start always restarts it
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            state_q <= P_IDLE;
        else if (frm_start)
            state_q <= P_FCF_LO;
        else if (oct_valid)
        begin
            unique case (state_q)
                P_IDLE: state_q <= P_IDLE;
                P_FCF_LO: state_q <= P_FCF_HI;
                P_FCF_HI: state_q <= P_BODY;
                P_BODY: state_q <= P_BODY;
            endcase
        end
    end

    // octet index from the first control field octet
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            idx_q <= NO_LEN;
        else if (frm_start)
            idx_q <= NO_LEN;
        else if (oct_valid && state_q != P_IDLE)
            idx_q <= idx_q + IDX_ONE;
    end

    // control field assembly, low octet first
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            lo_q <= '0;
            fcf_q <= '0;
            fcf_valid_q <= 1'b0;
        end
        else if (frm_start)
            fcf_valid_q <= 1'b0;
        else if (oct_valid && state_q == P_FCF_LO)
            lo_q <= oct_data; // [R18]
        else if (oct_valid && state_q == P_FCF_HI)
        begin
            fcf_q <= fcd_fcf_s'({oct_data, lo_q}); // [R1] [R18]
            fcf_valid_q <= 1'b1;
        end
    end

    // layout trails the field by one cycle; the earliest octet using it is
    // index three, so back-to-back octets still see a settled layout
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            layout_q <= '0;
        else
            layout_q <= fcd_layout(fcf_q); // [R16]
    end

    // octet past the control field, where the header fields are read
    assign in_body = oct_valid && state_q == P_BODY;
    // sequence number, broadcast destination and command id capture
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            seq_q <= '0;
            bcast_q <= 1'b0;
            data_req_q <= 1'b0;
        end
        else if (frm_start)
        begin
            bcast_q <= 1'b0;
            data_req_q <= 1'b0;
        end
        else if (in_body)
        begin
            if (idx_q == SEQ_OFS)
            begin
                seq_q <= oct_data; // [R17]
                bcast_q <= (fcf_q.dst_mode == AM_SHORT); // [R8]
            end
            // any non-ff octet of the short address clears broadcast
            if ((idx_q == layout_q.dst_adr_ofs || idx_q == layout_q.dst_adr_ofs + IDX_ONE)
                && oct_data != BCAST_OCT)
                bcast_q <= 1'b0;
            // secured payload is ciphered, so its command id is not read
            if (idx_q == layout_q.pay_ofs && fcf_q.ftype == FT_CMD && !fcf_q.secured)
                data_req_q <= (oct_data == CMD_DATA_REQ); // [R7]
        end
    end

    // filter terms; the same filter serves basic and auto-ack modes
    assign type_ok = (fcf_q.ftype <= FT_CMD) || upload_reserved_frame_types; // [R2] [R3] [R4]
    assign sec_ok = !fcf_q.secured || accept_secured; // [R6]
    // policy n acks versions 0..n, so 3 also acks both reserved versions
    assign ver_ok = (fcf_q.version <= ack_frame_version_policy); // [R14] [R15]

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            frame_pass_q <= 1'b0;
        else
            frame_pass_q <= fcf_valid_q && type_ok && sec_ok; // [R5]
    end

    // direction and transmitted sequence are latched per frame
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            dir_tx_q <= 1'b0;
        else if (frm_start)
            dir_tx_q <= frm_dir_tx;
    end

    // clean receive end and the decision to acknowledge it
    assign rx_end_ok = frm_end && !dir_tx_q && frm_crc_ok && fcf_valid_q;
    assign ack_need = rx_end_ok && auto_ack_receive_mode && frame_pass_q && ver_ok
        && fcf_q.ack_req && !bcast_q
        && (fcf_q.ftype == FT_DATA || fcf_q.ftype == FT_CMD); // [R8]

    // acknowledgment frame control field: type ack, pending from flag and data request, all else clear
    always_comb
    begin
        ack_d = '0;
        ack_d.ftype = FT_ACK; // [R2]
        ack_d.pending = ack_pending_data_flag && data_req_q; // [R7]
    end

    // ack request pulse with its field and copied sequence number
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ack_start_q <= 1'b0;
            ack_fcf_q <= '0;
            ack_seq_q <= '0;
        end
        else
        begin
            ack_start_q <= ack_need;
            if (ack_need)
            begin
                ack_fcf_q <= ack_d;
                ack_seq_q <= seq_q; // [R17]
            end
        end
    end

    // ack window watchdog; a new request in the sent cycle wins
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ack_busy_q <= 1'b0;
            ack_cnt_q <= '0;
            ack_timeout_q <= 1'b0;
        end
        else
        begin
            ack_timeout_q <= 1'b0;
            if (ack_start_q)
            begin
                ack_busy_q <= 1'b1;
                ack_cnt_q <= '0;
            end
            else if (ack_sent)
                ack_busy_q <= 1'b0;
            else if (ack_busy_q)
            begin
                if (ack_cnt_q == 32'(ACK_WINDOW - 2)) // [R8]
                begin
                    ack_busy_q <= 1'b0;
                    ack_timeout_q <= 1'b1;
                end
                else
                    ack_cnt_q <= ack_cnt_q + 32'h1;
            end
        end
    end

    // a returning ack matches on type and sequence number
    assign ack_seen = rx_end_ok && fcf_q.ftype == FT_ACK && seq_q == tx_seq_q;
    // retry-transmit: wait for an ack only if one was requested
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            retry_wait_ack_q <= 1'b0;
            retry_done_q <= 1'b0;
            tx_seq_q <= '0;
        end
        else
        begin
            retry_done_q <= 1'b0;
            if (frm_end && dir_tx_q && auto_retry_transmit_mode && fcf_valid_q)
            begin
                tx_seq_q <= seq_q;
                retry_wait_ack_q <= fcf_q.ack_req; // [R9]
                retry_done_q <= !fcf_q.ack_req; // [R9]
            end
            else if (frm_start && frm_dir_tx)
                retry_wait_ack_q <= 1'b0;
            else if (retry_wait_ack_q && ack_seen)
            begin
                retry_wait_ack_q <= 1'b0;
                retry_done_q <= 1'b1;
            end
        end
    end

    // checks next to the logic they guard
    AST_FCF_ORDER: assert property (@(posedge clk) disable iff (!rst_n) // [R1] [R18]
        (oct_valid && !frm_start && state_q == P_FCF_HI)
        |=> fcf_valid_q && fcf_q == fcd_fcf_s'({$past(oct_data), $past(lo_q)}))
        else $error("control field not assembled low octet first");
    AST_RSVD_REJECT: assert property (@(posedge clk) disable iff (!rst_n) // [R3]
        (fcf_q.ftype > FT_CMD && !upload_reserved_frame_types) |=> !frame_pass_q)
        else $error("reserved frame type passed the filter");
    AST_RSVD_UPLOAD: assert property (@(posedge clk) disable iff (!rst_n) // [R4]
        (fcf_valid_q && fcf_q.ftype > FT_CMD && upload_reserved_frame_types
        && !fcf_q.secured) |=> frame_pass_q)
        else $error("reserved frame type not uploaded");
    AST_SEC_FILTER: assert property (@(posedge clk) disable iff (!rst_n) // [R6]
        (fcf_q.secured && !accept_secured) |=> !frame_pass_q)
        else $error("secured frame passed with secured frames refused");
    AST_ACK_PEND: assert property (@(posedge clk) disable iff (!rst_n) // [R7]
        ack_start_q |-> ack_fcf_q.pending == ($past(ack_pending_data_flag) && $past(data_req_q)))
        else $error("ack pending bit does not follow the pending flag");
    AST_ACK_CAUSE: assert property (@(posedge clk) disable iff (!rst_n) // [R8]
        ack_start_q |-> $past(fcf_q.ack_req) && !$past(bcast_q) && $past(auto_ack_receive_mode)
        && ack_fcf_q.ftype == FT_ACK)
        else $error("ack issued without a valid cause");
    AST_ACK_SEQ: assert property (@(posedge clk) disable iff (!rst_n) // [R17]
        ack_start_q |-> ack_seq_q == $past(seq_q))
        else $error("ack sequence number not copied");
    AST_ACK_VER: assert property (@(posedge clk) disable iff (!rst_n) // [R15]
        ack_start_q |-> $past(fcf_q.version) <= $past(ack_frame_version_policy))
        else $error("ack sent for a version the policy refuses");
    AST_RETRY_NOACK: assert property (@(posedge clk) disable iff (!rst_n) // [R9]
        (frm_end && dir_tx_q && auto_retry_transmit_mode && fcf_valid_q && !fcf_q.ack_req)
        |=> retry_done_q && !retry_wait_ack_q)
        else $error("retry transaction did not end at once");
    AST_PAN_COMP: assert property (@(posedge clk) disable iff (!rst_n) // [R10]
        (fcf_q.pan_comp && fcf_q.dst_mode[1] && fcf_q.src_mode[1])
        |=> layout_q.src_adr_ofs == layout_q.src_pan_ofs)
        else $error("source pan-id kept under compression");
    AST_DST_LAYOUT: assert property (@(posedge clk) disable iff (!rst_n) // [R12]
        (fcf_q.dst_mode == AM_EXT && $stable(fcf_q))
        |=> layout_q.src_pan_ofs == layout_q.dst_pan_ofs + PAN_LEN + EXT_LEN)
        else $error("extended destination layout wrong");
    COV_ACK: cover property (@(posedge clk) disable iff (!rst_n) ack_start_q);
    COV_ACK_PEND: cover property (@(posedge clk) disable iff (!rst_n)
        ack_start_q && ack_fcf_q.pending);
    COV_RETRY_ACK: cover property (@(posedge clk) disable iff (!rst_n)
        retry_wait_ack_q ##1 retry_done_q);
    COV_TIMEOUT: cover property (@(posedge clk) disable iff (!rst_n) ack_timeout_q);
endmodule : fcd_decoder

//--- hdl/fcd_pkg.sv
// frame control field decoder: shared constants, field layout and states
// assumes octets arrive in air order, one per valid strobe, on clk
package fcd_pkg;
    // clock and acknowledgment timing
    localparam int CLK_PERIOD_NS = 5;
    localparam int ACK_TIME_NS = 192000;
    localparam int ACK_WINDOW_CYC = ACK_TIME_NS / CLK_PERIOD_NS;

    // octet widths and positions inside the mpdu
    localparam int OCT_W = 8;
    localparam int IDX_W = 7;
    localparam logic [IDX_W-1:0] SEQ_OFS = 7'h02;
    localparam logic [IDX_W-1:0] HDR_OFS = 7'h03;
    localparam logic [IDX_W-1:0] PAN_LEN = 7'h02;
    localparam logic [IDX_W-1:0] SHORT_LEN = 7'h02;
    localparam logic [IDX_W-1:0] EXT_LEN = 7'h08;
    localparam logic [IDX_W-1:0] NO_LEN = 7'h00;
    localparam logic [IDX_W-1:0] IDX_ONE = 7'h01;

    // frame type codes
    localparam logic [2:0] FT_BEACON = 3'h0;
    localparam logic [2:0] FT_DATA = 3'h1;
    localparam logic [2:0] FT_ACK = 3'h2;
    localparam logic [2:0] FT_CMD = 3'h3;

    // addressing modes and frame versions
    localparam logic [1:0] AM_NONE = 2'h0;
    localparam logic [1:0] AM_RSVD = 2'h1;
    localparam logic [1:0] AM_SHORT = 2'h2;
    localparam logic [1:0] AM_EXT = 2'h3;
    localparam logic [1:0] FV_2003 = 2'h0;
    localparam logic [1:0] FV_2006 = 2'h1;

    // octet values
    localparam logic [OCT_W-1:0] BCAST_OCT = 8'hFF;
    localparam logic [OCT_W-1:0] CMD_DATA_REQ = 8'h04;

    // field layout, msb first so a 16-bit word casts straight onto it
    typedef struct packed {
        logic [1:0] src_mode;
        logic [1:0] version;
        logic [1:0] dst_mode;
        logic [2:0] rsvd;
        logic pan_comp;
        logic ack_req;
        logic pending;
        logic secured;
        logic [2:0] ftype;
    } fcd_fcf_s;

    // octet offsets of the addressing fields, fed to the address filter
    typedef struct packed {
        logic [IDX_W-1:0] dst_pan_ofs;
        logic [IDX_W-1:0] dst_adr_ofs;
        logic [IDX_W-1:0] src_pan_ofs;
        logic [IDX_W-1:0] src_adr_ofs;
        logic [IDX_W-1:0] pay_ofs;
    } fcd_layout_s;

    typedef enum logic [1:0] {P_IDLE, P_FCF_LO, P_FCF_HI, P_BODY} fcd_parse_e;
endpackage : fcd_pkg

//--- sim/fcd_node_model.sv
// remote radio node model: plays mpdu octets into the decoder
// assumes the bench calls send_frame from one process, inputs change on negedge
`timescale 1ns/100ps
module fcd_node_model
    import fcd_pkg::*;
(
    // clock
    input wire logic clk,
    // octet stream toward the decoder
    output logic frm_start,
    output logic frm_dir_tx,
    output logic oct_valid,
    output logic [OCT_W-1:0] oct_data,
    output logic frm_end,
    output logic frm_crc_ok
);
    // idle bus at time zero
    initial
    begin
        frm_start = 1'b0;
        frm_dir_tx = 1'b0;
        oct_valid = 1'b0;
        oct_data = 8'hA5;
        frm_end = 1'b0;
        frm_crc_ok = 1'b0;
    end

    // octets go out in air order, low control octet first
    task automatic send_frame(input logic tx, input logic crc, input logic [7:0] q[$]);
        @(negedge clk);
        frm_start = 1'b1;
        frm_dir_tx = tx;
        @(negedge clk);
        frm_start = 1'b0;
        foreach (q[i])
        begin
            oct_valid = 1'b1;
            oct_data = q[i];
            @(negedge clk);
        end
        oct_valid = 1'b0;
        oct_data = ~oct_data; // stale octet must not look valid
        frm_end = 1'b1;
        frm_crc_ok = crc;
        @(negedge clk);
        frm_end = 1'b0;
        frm_crc_ok = ~crc;
        frm_dir_tx = ~tx;
    endtask : send_frame
endmodule : fcd_node_model

//--- sim/tb_frame_control_field_decoder.sv
// bench for the control field decoder: random and corner frames from the node model
// assumes a short ack window so timeouts fit in the run
`timescale 1ns/100ps
module tb_frame_control_field_decoder
    import fcd_pkg::*;
;
    localparam int WIN = 40;
    logic clk, rst_n, fs, ftx, ov, fe, fok, aa, ar, upl, pdf, acc, ack_sent;
    logic [7:0] od;
    logic [1:0] pol;
    fcd_fcf_s fcf_q, ack_fcf_q;
    fcd_layout_s layout_q;
    logic fv, fp, ack_start_q, ack_to, r_wait, r_done;
    logic [7:0] ack_seq_q;
    int miscompares = 0;
    int samples_checked = 0;

    fcd_node_model node (.clk(clk), .frm_start(fs), .frm_dir_tx(ftx), .oct_valid(ov),
        .oct_data(od), .frm_end(fe), .frm_crc_ok(fok));

    fcd_decoder #(.ACK_WINDOW(WIN)) dut (.clk(clk), .rst_n(rst_n), .frm_start(fs),
        .frm_dir_tx(ftx), .oct_valid(ov), .oct_data(od), .frm_end(fe), .frm_crc_ok(fok),
        .auto_ack_receive_mode(aa), .auto_retry_transmit_mode(ar),
        .upload_reserved_frame_types(upl), .ack_pending_data_flag(pdf),
        .ack_frame_version_policy(pol), .accept_secured(acc), .ack_sent(ack_sent),
        .fcf_q(fcf_q), .fcf_valid_q(fv), .layout_q(layout_q), .frame_pass_q(fp),
        .ack_start_q(ack_start_q), .ack_fcf_q(ack_fcf_q), .ack_seq_q(ack_seq_q),
        .ack_timeout_q(ack_to), .retry_wait_ack_q(r_wait), .retry_done_q(r_done));

    // free-running 200 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic check(input string what, input logic [34:0] seen, input logic [34:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : tally_and_finish

    // count high cycles of a pulse over a fixed window, sampled at negedge
    task automatic count_hi(input int n, ref logic sig, output int c);
        c = 0;
        repeat (n)
        begin
            if (sig !== 1'b0) // an unknown counts as high so it cannot hide
                c++;
            @(negedge clk);
        end
    endtask : count_hi

    // offsets accumulate; absent or reserved fields take no octets
    function automatic logic [34:0] exp_layout(input fcd_fcf_s f);
        logic [IDX_W-1:0] dp, da, sp, sa, pl;
        logic dpr, spr;
        dpr = f.dst_mode[1];
        spr = f.src_mode[1];
        dp = HDR_OFS;
        da = dp + (dpr ? PAN_LEN : NO_LEN);
        sp = da + (!dpr ? NO_LEN : f.dst_mode[0] ? EXT_LEN : SHORT_LEN);
        sa = sp + ((spr && !(f.pan_comp && dpr)) ? PAN_LEN : NO_LEN);
        pl = sa + (!spr ? NO_LEN : f.src_mode[0] ? EXT_LEN : SHORT_LEN);
        return {dp, da, sp, sa, pl};
    endfunction : exp_layout

    // hang guard well above the planned run length
    initial
    begin
        #400000;
        miscompares++;
        tally_and_finish();
    end

    initial
    begin
        fcd_fcf_s f;
        logic [7:0] q[$];
        logic [7:0] seq, p0;
        logic tx, crc, bc, sa_send, pass, en, pend;
        int c, n;
        {aa, ar, upl, pdf, acc, ack_sent} = 6'h00;
        pol = 2'h0;
        rst_n = 1'b0;
        void'($urandom(32'h6183));
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        for (int i = 0; i < 70; i++)
        begin
            f = fcd_fcf_s'(16'($urandom));
            seq = 8'($urandom);
            tx = (i >= 8) && ($urandom % 4 == 0);
            crc = (i < 8) || ($urandom % 8 != 0);
            bc = ($urandom % 3 == 0);
            sa_send = 1'($urandom % 2);
            p0 = ($urandom % 2) ? CMD_DATA_REQ : 8'($urandom);
            {upl, pdf, acc} = 3'($urandom);
            pol = 2'($urandom);
            aa = (i < 8) || ($urandom % 4 != 0);
            ar = tx;
            if (i < 8)
            begin
                f.ftype = 3'(i); // every frame type once, reserved ones too
                f.ack_req = 1'b1;
            end
            q = {f[7:0], f[15:8], seq};
            if (f.dst_mode[1])
            begin
                q.push_back(8'($urandom));
                q.push_back(8'($urandom));
                n = f.dst_mode[0] ? 8 : 2;
                repeat (n) q.push_back(bc ? BCAST_OCT : 8'($urandom));
            end
            if (f.src_mode[1])
            begin
                n = (f.src_mode[0] ? 8 : 2) + ((f.pan_comp && f.dst_mode[1]) ? 0 : 2);
                repeat (n) q.push_back(8'($urandom));
            end
            q.push_back(p0);
            q.push_back(8'($urandom));
            node.send_frame(tx, crc, q);
            pass = ((f.ftype < 3'h4) || upl) && (!f.secured || acc);
            en = !tx && crc && aa && pass && (f.ftype == FT_DATA || f.ftype == FT_CMD)
                && f.ack_req && !(f.dst_mode == AM_SHORT && bc) && (f.version <= pol);
            pend = pdf && f.ftype == FT_CMD && !f.secured && p0 == CMD_DATA_REQ;
            check("fcf", 35'(fcf_q), 35'(f));
            check("fcf_valid", 35'(fv), 35'h1);
            check("layout", 35'(layout_q), exp_layout(f));
            check("pass", 35'(fp), 35'(pass));
            if (tx)
            begin
                count_hi(3, r_done, c);
                check("retry_done", 35'(c), 35'(!f.ack_req));
                check("retry_wait", 35'(r_wait), 35'(f.ack_req));
                if (f.ack_req)
                begin
                    // an ack with a foreign sequence number must not end the wait
                    if ($urandom % 2 == 0)
                    begin
                        node.send_frame(1'b0, 1'b1, {8'h02, 8'h00, ~seq});
                        count_hi(3, r_done, c);
                        check("retry_foreign_ack", 35'(c), 35'h0);
                        check("retry_still_wait", 35'(r_wait), 35'h1);
                    end
                    node.send_frame(1'b0, 1'b1, {8'h02, 8'h00, seq});
                    count_hi(3, r_done, c);
                    check("retry_ack_done", 35'(c), 35'h1);
                    check("retry_ack_wait", 35'(r_wait), 35'h0);
                end
            end
            else
            begin
                count_hi(3, ack_start_q, c);
                check("ack_start", 35'(c), 35'(en));
                if (en)
                begin
                    check("ack_fcf", 35'(ack_fcf_q), {19'h0, 16'h0002 | 16'(pend) << 4});
                    check("ack_seq", 35'(ack_seq_q), 35'(seq));
                end
                // a sent mark with no ack pending must be ignored
                ack_sent = sa_send;
                @(negedge clk);
                ack_sent = 1'b0;
                count_hi(WIN + 10, ack_to, c);
                check("ack_timeout", 35'(c), 35'(en && !sa_send));
            end
            $display("frame %0d tx %0d type %0d done", i, tx, f.ftype);
        end
        tally_and_finish();
    end
endmodule : tb_frame_control_field_decoder
